// *** rtcp_regs.sv ***
// Prescaler and alarm-0 register slice with AXI4-Lite slave, dividers and alarm compare.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module rtcp_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic nbkpRst,
  input wire logic rtcInputTick,
  input wire logic [31:0] calendarNow,
  input wire logic [rtcp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rtcp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic asyncPrescaledClk,
  output logic calendarTickClk,
  output logic initStateFlag,
  output logic alarmMatch
);

  function automatic rtcp_pkg::rtcp_sel_e decodeSel(input logic [rtcp_pkg::ADDR_W-1:0] addr);
    case (addr)
      rtcp_pkg::OFS_CTRL: decodeSel = rtcp_pkg::SEL_CTRL;
      rtcp_pkg::OFS_PSC: decodeSel = rtcp_pkg::SEL_PSC;
      rtcp_pkg::OFS_ALRM: decodeSel = rtcp_pkg::SEL_ALRM;
      default: decodeSel = rtcp_pkg::SEL_NONE;
    endcase
  endfunction

  rtcp_pkg::rtcp_psc_s prescaler;
  rtcp_pkg::rtcp_alarm_s alarm0;
  rtcp_pkg::rtcp_alarm_s nowFields;
  rtcp_pkg::rtcp_psc_s next_prescaler;
  logic initRequest;
  logic initFlag;
  logic [rtcp_pkg::ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic awHeld;
  logic wHeld;
  rtcp_pkg::rtcp_sel_e wSel;
  rtcp_pkg::rtcp_sel_e rSel;
  logic wrFire;
  logic fullWord;
  logic wrOk;
  logic initExit;
  logic dateHit;
  logic hourHit;
  logic minuteHit;
  logic secondHit;
  logic [31:0] ctrlWord;
  logic [31:0] readWord;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wrFire = awHeld && wHeld && !s_axi_bvalid;
  assign wSel = decodeSel(awAddr);
  assign rSel = decodeSel(s_axi_araddr);
  assign fullWord = &wStrb;
  assign wrOk = (wSel != rtcp_pkg::SEL_NONE) && fullWord && ((wSel == rtcp_pkg::SEL_CTRL) || initFlag);
  assign next_prescaler = rtcp_pkg::rtcp_psc_s'(wData & rtcp_pkg::PSC_FIELD_MASK);
  assign initStateFlag = initFlag;

  // Write address and data are latched separately so either may arrive first.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rtcp_pkg::RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrOk ? rtcp_pkg::RESP_OKAY : rtcp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nbkpRst) begin
      prescaler <= rtcp_pkg::rtcp_psc_s'(rtcp_pkg::PSC_RESET);
    end else if (wrFire && wrOk && (wSel == rtcp_pkg::SEL_PSC)) begin
      prescaler <= next_prescaler;
    end
  end

  always_ff @(posedge clk) begin
    if (!nbkpRst) begin
      alarm0 <= rtcp_pkg::rtcp_alarm_s'(rtcp_pkg::ALRM_RESET);
    end else if (wrFire && wrOk && (wSel == rtcp_pkg::SEL_ALRM)) begin
      alarm0 <= rtcp_pkg::rtcp_alarm_s'(wData);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      initRequest <= 1'b0;
      initFlag <= 1'b0;
    end else begin
      if (wrFire && wrOk && (wSel == rtcp_pkg::SEL_CTRL)) begin
        initRequest <= wData[rtcp_pkg::CTRL_INIT_REQ_BIT];
      end
      initFlag <= initRequest;
    end
  end

  assign ctrlWord = (32'(alarmMatch) << rtcp_pkg::CTRL_MATCH_BIT) |
                    (32'(initRequest) << rtcp_pkg::CTRL_INIT_REQ_BIT) |
                    (32'(initFlag) << rtcp_pkg::CTRL_INIT_FLAG_BIT);
  assign readWord = (rSel == rtcp_pkg::SEL_CTRL) ? ctrlWord :
                    (rSel == rtcp_pkg::SEL_PSC) ? 32'(prescaler) :
                    (rSel == rtcp_pkg::SEL_ALRM) ? 32'(alarm0) : 32'h00000000;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= rtcp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readWord;
      s_axi_rresp <= (rSel == rtcp_pkg::SEL_NONE) ? rtcp_pkg::RESP_SLVERR : rtcp_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign initExit = initFlag && !initRequest;

  rtcp_divider #(.W(rtcp_pkg::FACTOR_A_W)) asyncStage (
    .clk(clk),
    .nrst(nrst),
    .tickIn(rtcInputTick),
    .factor(prescaler.factorA),
    .run(!initFlag),
    .reload(initExit),
    .tickOut(asyncPrescaledClk)
  );

  rtcp_divider #(.W(rtcp_pkg::FACTOR_S_W)) syncStage (
    .clk(clk),
    .nrst(nrst),
    .tickIn(asyncPrescaledClk),
    .factor(prescaler.factorS),
    .run(!initFlag),
    .reload(initExit),
    .tickOut(calendarTickClk)
  );

  assign nowFields = rtcp_pkg::rtcp_alarm_s'(calendarNow);
  // date mask drops the day field.
  assign dateHit = alarm0.dateMask || ({alarm0.weekdaySelect, alarm0.dayTens, alarm0.dayUnits} ==
                   {nowFields.weekdaySelect, nowFields.dayTens, nowFields.dayUnits});
  assign hourHit = alarm0.hourMask || ({alarm0.afternoonFlag, alarm0.hourTens, alarm0.hourUnits} ==
                   {nowFields.afternoonFlag, nowFields.hourTens, nowFields.hourUnits});
  assign minuteHit = alarm0.minuteMask || ({alarm0.minuteTens, alarm0.minuteUnits} ==
                     {nowFields.minuteTens, nowFields.minuteUnits});
  assign secondHit = alarm0.secondMask || ({alarm0.secondTens, alarm0.secondUnits} ==
                     {nowFields.secondTens, nowFields.secondUnits});

  // The match is suppressed in init state because the calendar is not running.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      alarmMatch <= 1'b0;
    end else begin
      alarmMatch <= dateHit && hourHit && minuteHit && secondHit && !initFlag;
    end
  end

  a_protect_psc_write: assert property (@(posedge clk) disable iff (!nrst || !nbkpRst)
    (wrFire && (wSel == rtcp_pkg::SEL_PSC) && !initFlag) |=> $stable(prescaler))
    else $error("Prescaler changed outside init state.");

  a_partial_strobe_err: assert property (@(posedge clk) disable iff (!nrst)
    (wrFire && !fullWord) |=> s_axi_bvalid && (s_axi_bresp == rtcp_pkg::RESP_SLVERR))
    else $error("Partial write was not refused.");

  a_psc_bkp_reset: assert property (@(posedge clk)
    !nbkpRst |=> (32'(prescaler) == rtcp_pkg::PSC_RESET))
    else $error("Prescaler missed its backup reset value.");

  a_psc_sys_keep: assert property (@(posedge clk) disable iff (!nbkpRst)
    (!nrst && !wrFire) |=> $stable(prescaler))
    else $error("System reset disturbed the prescaler.");

  a_alarm_bkp_reset: assert property (@(posedge clk)
    !nbkpRst |=> (32'(alarm0) == rtcp_pkg::ALRM_RESET))
    else $error("Alarm register missed its backup reset value.");

  a_alarm_sys_keep: assert property (@(posedge clk) disable iff (!nbkpRst)
    (!nrst && !wrFire) |=> $stable(alarm0))
    else $error("System reset disturbed the alarm register.");

  a_date_mask_skip: assert property (@(posedge clk) disable iff (!nrst || !nbkpRst)
    (alarm0.dateMask && hourHit && minuteHit && secondHit && !initFlag) |=> alarmMatch)
    else $error("Masked date field blocked the alarm.");

  a_init_enter: assert property (@(posedge clk) disable iff (!nrst)
    $rose(initRequest) |-> ##1 initFlag ##1 !calendarTickClk)
    else $error("Init state not entered after request.");

  a_tick_stopped: assert property (@(posedge clk) disable iff (!nrst)
    initFlag[*2] |-> !calendarTickClk && !asyncPrescaledClk)
    else $error("Calendar tick ran in init state.");

  a_exit_restart: assert property (@(posedge clk) disable iff (!nrst)
    initExit |=> !initFlag && !asyncPrescaledClk && !calendarTickClk)
    else $error("Dividers did not restart on init exit.");

endmodule // rtcp_regs

// *** rtcp_pkg.sv ***
// Package with register map, field layouts and constants of the calendar prescaler and alarm slice.
// Behaviour
// - Prescaler and alarm-0 writes take effect only while initialization state is active.
// - Input ticks divided by asynchronous factor plus one give the intermediate tick.
// - Intermediate ticks divided by synchronous factor plus one give the calendar tick.
// - Prescaler at 0x10 resets to 0x007f00ff on backup reset only.
// - Alarm-0 at 0x1c clears on backup reset only; system reset leaves it.
// - Alarm upper half: date mask, weekday select, day tens/units, hour mask, pm, hour digits.
// - Alarm lower half: minute mask, minute tens/units, second mask, second tens/units.
// - A set date mask drops the date/day field from the alarm comparison.
// - Init request stops the calendar counter and permits programming; clearing resumes.
package rtcp_pkg;

  localparam int ADDR_W = 8;
  localparam int FACTOR_A_W = 7;
  localparam int FACTOR_S_W = 15;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_PSC = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ALRM = 8'h1c;

  localparam logic [31:0] PSC_RESET = 32'h007f00ff;
  localparam logic [31:0] PSC_FIELD_MASK = 32'h007f7fff;
  localparam logic [31:0] ALRM_RESET = 32'h00000000;

  localparam int CTRL_MATCH_BIT = 8;
  localparam int CTRL_INIT_REQ_BIT = 7;
  localparam int CTRL_INIT_FLAG_BIT = 6;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SEL_NONE, SEL_CTRL, SEL_PSC, SEL_ALRM} rtcp_sel_e;

  typedef struct packed {
    logic [8:0] rsvdHigh;
    logic [FACTOR_A_W-1:0] factorA;
    logic rsvdMid;
    logic [FACTOR_S_W-1:0] factorS;
  } rtcp_psc_s;

  typedef struct packed {
    logic dateMask;
    logic weekdaySelect;
    logic [1:0] dayTens;
    logic [3:0] dayUnits;
    logic hourMask;
    logic afternoonFlag;
    logic [1:0] hourTens;
    logic [3:0] hourUnits;
    logic minuteMask;
    logic [2:0] minuteTens;
    logic [3:0] minuteUnits;
    logic secondMask;
    logic [2:0] secondTens;
    logic [3:0] secondUnits;
  } rtcp_alarm_s;

endpackage

// *** rtcp_divider.sv ***
// Counting divider that emits one pulse per factor plus one input pulses.
`timescale 1ns/1ps
module rtcp_divider #(
  parameter int W = 7
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tickIn,
  input wire logic [W-1:0] factor,
  input wire logic run,
  input wire logic reload,
  output logic tickOut
);

  logic [W-1:0] count;
  logic atEnd;

  assign atEnd = (count == factor);

  always_ff @(posedge clk) begin
    if (!nrst || reload || !run) begin
      count <= '0;
      tickOut <= 1'b0;
    end else begin
      tickOut <= tickIn && atEnd;
      if (tickIn) begin
        count <= atEnd ? '0 : W'(count + 1'b1);
      end
    end
  end

  a_divide_ratio: assert property (@(posedge clk) disable iff (!nrst)
    tickOut |-> $past(tickIn) && ($past(count) == $past(factor)) && (count == '0))
    else $error("Divider pulsed at the wrong count.");

endmodule // rtcp_divider

// *** tb_rtc_prescaler_alarm_regs.sv ***
// Self-checking testbench for the prescaler and alarm-0 register slice.
`timescale 1ns/1ps
module tb_rtc_prescaler_alarm_regs;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic nbkpRst = 1'b0;
  logic rtcInputTick = 1'b0;
  logic [31:0] calendarNow = 32'h07123456;
  logic [rtcp_pkg::ADDR_W-1:0] awaddr = '0;
  logic [rtcp_pkg::ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, apre, ctick, initFlag, match;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] pscM = rtcp_pkg::PSC_RESET;
  logic [31:0] alrmM = rtcp_pkg::ALRM_RESET;
  logic init_request = 1'b0;
  int seed = 32'hfa1e1346;
  int nMismatch = 0, compares = 0, nA = 0, nC = 0;
  int i, k, a0, c0;

  rtcp_regs DUT (.clk(clk), .nrst(nrst), .nbkpRst(nbkpRst), .rtcInputTick(rtcInputTick),
    .calendarNow(calendarNow), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .asyncPrescaledClk(apre), .calendarTickClk(ctick),
    .initStateFlag(initFlag), .alarmMatch(match));

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (apre === 1'b1) nA++;
    if (ctick === 1'b1) nC++;
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic mm(input logic [31:0] a, input logic [31:0] n);
    return (a[31] || a[30:24] == n[30:24]) && (a[23] || a[22:16] == n[22:16]) &&
      (a[15] || a[14:8] == n[14:8]) && (a[7] || a[6:0] == n[6:0]);
  endfunction

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic pa, pw;
    logic [1:0] er;
    pa = 1'b1;
    pw = 1'b1;
    er = rtcp_pkg::RESP_SLVERR;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && awready === 1'b1) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && wready === 1'b1) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    if (s == 4'hf && a == rtcp_pkg::OFS_CTRL) begin
      init_request = d[7];
      er = rtcp_pkg::RESP_OKAY;
    end else if (s == 4'hf && init_request && a == rtcp_pkg::OFS_PSC) begin
      pscM = d & rtcp_pkg::PSC_FIELD_MASK;
      er = rtcp_pkg::RESP_OKAY;
    end else if (s == 4'hf && init_request && a == rtcp_pkg::OFS_ALRM) begin
      alrmM = d;
      er = rtcp_pkg::RESP_OKAY;
    end
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task rd(input logic [7:0] a);
    logic [31:0] ed;
    logic [1:0] er;
    ed = 32'h0;
    er = rtcp_pkg::RESP_OKAY;
    case (a)
      rtcp_pkg::OFS_CTRL: ed = {24'h0, init_request, init_request, 6'h0};
      rtcp_pkg::OFS_PSC: ed = pscM;
      rtcp_pkg::OFS_ALRM: ed = alrmM;
      default: er = rtcp_pkg::RESP_SLVERR;
    endcase
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", ed, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task setInit(input logic v);
    wr(rtcp_pkg::OFS_CTRL, {24'h0, v, 7'h0}, 4'hf);
    repeat (3) @(posedge clk);
    chk("init flag", {31'h0, v}, {31'h0, initFlag});
  endtask

  task ticks(input int n, output int cnt);
    logic b;
    cnt = 0;
    repeat (n) begin
      @(posedge clk);
      b = 1'($random(seed));
      rtcInputTick <= b;
      cnt += b;
    end
    @(posedge clk);
    rtcInputTick <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task stopTest;
    $display("Comparisons %0d, mismatches %0d", compares, nMismatch);
    if (nMismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    nMismatch++;
    stopTest;
  end

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    nbkpRst <= 1'b1;
    rd(rtcp_pkg::OFS_PSC);
    rd(rtcp_pkg::OFS_ALRM);
    rd(8'h24);
    wr(rtcp_pkg::OFS_PSC, 32'h00020003, 4'hf);
    wr(rtcp_pkg::OFS_ALRM, 32'h00000001, 4'hf);
    rd(rtcp_pkg::OFS_PSC);
    setInit(1'b1);
    rd(rtcp_pkg::OFS_CTRL);
    wr(rtcp_pkg::OFS_PSC, 32'h00020003, 4'h3);
    wr(8'h20, 32'h12345678, 4'hf);
    for (i = 0; i < 4; i++) begin
      wr(rtcp_pkg::OFS_ALRM, $random(seed), 4'hf);
      rd(rtcp_pkg::OFS_ALRM);
    end
    for (i = 0; i < 2; i++) begin
      wr(rtcp_pkg::OFS_PSC, (i == 1) ? 32'h00020003 : 32'h00000001, 4'hf);
      rd(rtcp_pkg::OFS_PSC);
      a0 = nA;
      ticks(40, k);
      chk("apre in init", a0, nA);
      setInit(1'b0);
      a0 = nA;
      c0 = nC;
      ticks(300, k);
      chk("apre count", a0 + k / (pscM[22:16] + 1), nA);
      chk("tick count", c0 + k / (pscM[22:16] + 1) / (pscM[14:0] + 1), nC);
      setInit(1'b1);
    end
    wr(rtcp_pkg::OFS_ALRM, 32'h95123456, 4'hf);
    calendarNow[31:24] <= 8'($random(seed));
    chk("match in init", 32'h0, {31'h0, match});
    setInit(1'b0);
    chk("match masked", {31'h0, mm(alrmM, calendarNow)}, {31'h0, match});
    setInit(1'b1);
    wr(rtcp_pkg::OFS_ALRM, 32'h15123456, 4'hf);
    setInit(1'b0);
    chk("match unmasked", {31'h0, mm(alrmM, calendarNow)}, {31'h0, match});
    calendarNow <= 32'h15123456;
    repeat (2) @(posedge clk);
    chk("match date hit", {31'h0, mm(alrmM, calendarNow)}, {31'h0, match});
    @(posedge clk);
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    init_request = 1'b0;
    rd(rtcp_pkg::OFS_PSC);
    rd(rtcp_pkg::OFS_ALRM);
    @(posedge clk);
    nbkpRst <= 1'b0;
    repeat (8) @(posedge clk);
    nbkpRst <= 1'b1;
    pscM = rtcp_pkg::PSC_RESET;
    alrmM = rtcp_pkg::ALRM_RESET;
    rd(rtcp_pkg::OFS_PSC);
    rd(rtcp_pkg::OFS_ALRM);
    stopTest;
  end
endmodule // tb_rtc_prescaler_alarm_regs
